// [rtl/sloe_defs.vh]
`ifndef SLOE_DEFS_VH
`define SLOE_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SLOE_REG_CTRL   6'h00
`define SLOE_REG_STATUS 6'h04
`define SLOE_REG_LIST   6'h08
`define SLOE_REG_BOOL   6'h0C
`define SLOE_REG_TDIM   6'h10
`define SLOE_REG_BWARP  6'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLOE_CTRL_GO    0
`define SLOE_CTRL_B2T   1
`define SLOE_ST_BUSY    0
`define SLOE_ST_DONE    1
`define SLOE_ST_FAULT   2
`define SLOE_ST_BAD     3
`define SLOE_NL_BIT     15
// ----------------------------------------
// Opcodes and order lengths in words
// ----------------------------------------
`define SLOE_OP_STOP    8'h00
`define SLOE_OP_TDIM    8'h0B
`define SLOE_OP_DFRAME  8'h14
`define SLOE_OP_TFRAME  8'h15
`define SLOE_OP_TSTRIP  8'h35
`define SLOE_LEN_TDIM   4'h5
`define SLOE_LEN_DFRAME 4'h6
`define SLOE_LEN_TFRAME 4'hC
`define SLOE_LEN_TSTRIP 4'hB
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLOE_RST_BOOL   8'h00
`define SLOE_RST_TDIM   16'h0001
`define SLOE_RST_BWARP  16'h0000
`endif

// [rtl/sloe_scanline_order_executor.v]
`timescale 1ns/1ps
`default_nettype none
`include "sloe_defs.vh"
module sloe_scanline_order_executor (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [31:0] avm_address,
  output reg         avm_read,
  output reg         avm_write,
  output reg  [15:0] avm_writedata,
  input  wire [15:0] avm_readdata,
  input  wire        avm_waitrequest,
  output reg         drawValid,
  input  wire        drawReady,
  output reg  [31:0] drawDest,
  output reg  [14:0] drawLen,
  output reg  [31:0] drawTone,
  output reg  [15:0] drawToneX,
  output reg  [15:0] drawToneWord,
  output reg         drawUseTone,
  output reg  [7:0]  drawCode,
  input  wire        bandFault
);
  localparam [3:0] S_IDLE = 4'h0, S_FETCH = 4'h1, S_DEC = 4'h2, S_SA = 4'h3;
  localparam [3:0] S_SB = 4'h4, S_TONE = 4'h5, S_DRAW = 4'h6, S_WB = 4'h7;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] sext;
    input [15:0] v;
    sext = {{16{v[15]}}, v};
  endfunction
  function [31:0] bmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      bmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i]) bmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction
  function [3:0] opLen;
    input [7:0] op;
    case (op)
      `SLOE_OP_TDIM:   opLen = `SLOE_LEN_TDIM;
      `SLOE_OP_DFRAME: opLen = `SLOE_LEN_DFRAME;
      `SLOE_OP_TFRAME: opLen = `SLOE_LEN_TFRAME;
      `SLOE_OP_TSTRIP: opLen = `SLOE_LEN_TSTRIP;
      default:         opLen = 4'h1;
    endcase
  endfunction
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [3:0]  state_q;
  reg [15:0] buf_q [0:11];
  reg [3:0]  idx_q;
  reg [31:0] listPtr_q, orderPtr_q;
  reg        b2t_q, done_q, fault_q, bad_q;
  reg [7:0]  boolD_q, boolHD_q;
  reg [15:0] toneW_q, toneH_q, bandWarp_q;
  reg [7:0]  op_q, strip_q;
  reg [31:0] pos_q, tone_q, ttp_q, stp_q;
  reg [15:0] warp_q, xRem_q, yRem_q, wordA_q, wordB_q;
  wire       toneOp = (op_q != `SLOE_OP_DFRAME);
  wire [31:0] toneSize = toneW_q * toneH_q;
  // ----------------------------------------
  // Next specifier placement
  // ----------------------------------------
  reg [15:0] disp, run;
  reg [31:0] lineDest, st, newPos, lineTone, stTone, newTone;
  reg [15:0] newY;
  always @* begin
    disp = b2t_q ? wordB_q : wordA_q;
    run  = b2t_q ? wordA_q : wordB_q;
    lineDest = pos_q;
    lineTone = tone_q;
    newY = yRem_q;
    if (run[`SLOE_NL_BIT]) begin
      newY = (yRem_q == 16'h0001) ? toneH_q : yRem_q - 16'h0001;
      if (b2t_q) begin
        lineDest = pos_q - {16'h0000, warp_q};
        lineTone = (yRem_q == 16'h0001) ? tone_q - {16'h0000, toneW_q} + toneSize
                                        : tone_q - {16'h0000, toneW_q};
      end else begin
        lineDest = pos_q + {16'h0000, warp_q};
        lineTone = (yRem_q == 16'h0001) ? tone_q + {16'h0000, toneW_q} - toneSize
                                        : tone_q + {16'h0000, toneW_q};
      end
    end
    if (b2t_q) begin
      st     = lineDest - {17'h00000, run[14:0]};
      stTone = lineTone - {17'h00000, run[14:0]};
      newPos = st - sext(disp);
      newTone = stTone - sext(disp);
    end else begin
      st     = lineDest + sext(disp);
      stTone = lineTone + sext(disp);
      newPos = st + {17'h00000, run[14:0]};
      newTone = stTone + {17'h00000, run[14:0]};
    end
  end
  // ----------------------------------------
  // Band fault write-back words
  // ----------------------------------------
  function [15:0] wbWord;
    input [3:0] i;
    case (i)
      4'h0:    wbWord = {op_q, b2t_q ? strip_q - 8'h01 : strip_q + 8'h01};
      4'h1:    wbWord = pos_q[31:16];
      4'h2:    wbWord = pos_q[15:0];
      4'h3:    wbWord = xRem_q;
      4'h4:    wbWord = yRem_q;
      4'h5:    wbWord = tone_q[31:16];
      4'h6:    wbWord = tone_q[15:0];
      4'h7:    wbWord = ttp_q[31:16];
      4'h8:    wbWord = ttp_q[15:0];
      4'h9:    wbWord = stp_q[31:16];
      default: wbWord = stp_q[15:0];
    endcase
  endfunction
  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  wire       busy = (state_q != S_IDLE);
  wire       acc  = (avs_read | avs_write) & avs_waitrequest;
  wire       wrEn = avs_write & !avs_waitrequest;
  wire [31:0] boolMerge = bmerge({16'h0000, boolHD_q, boolD_q}, avs_writedata, avs_byteenable);
  wire [31:0] warpMerge = bmerge({16'h0000, bandWarp_q}, avs_writedata, avs_byteenable);
  wire       goReq = wrEn && avs_address == `SLOE_REG_CTRL
                     && avs_byteenable[0] && avs_writedata[`SLOE_CTRL_GO] && !busy;
  reg [31:0] rdMux;
  always @* begin
    case (avs_address)
      `SLOE_REG_CTRL:   rdMux = {30'h00000000, b2t_q, 1'b0};
      `SLOE_REG_STATUS: rdMux = {28'h0000000, bad_q, fault_q, done_q, busy};
      `SLOE_REG_LIST:   rdMux = listPtr_q;
      `SLOE_REG_BOOL:   rdMux = {16'h0000, boolHD_q, boolD_q};
      `SLOE_REG_TDIM:   rdMux = {toneH_q, toneW_q};
      `SLOE_REG_BWARP:  rdMux = {16'h0000, bandWarp_q};
      default:          rdMux = 32'h00000000;
    endcase
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !acc;
      if (avs_read & avs_waitrequest) avs_readdata <= rdMux;
    end
  end
  // ----------------------------------------
  // Order executor
  // ----------------------------------------
  wire memDone = (avm_read | avm_write) & !avm_waitrequest;
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      idx_q <= 4'h0;
      listPtr_q <= 32'h00000000;
      orderPtr_q <= 32'h00000000;
      b2t_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      bad_q <= 1'b0;
      boolD_q <= `SLOE_RST_BOOL;
      boolHD_q <= `SLOE_RST_BOOL;
      toneW_q <= `SLOE_RST_TDIM;
      toneH_q <= `SLOE_RST_TDIM;
      bandWarp_q <= `SLOE_RST_BWARP;
      op_q <= 8'h00;
      strip_q <= 8'h00;
      pos_q <= 32'h00000000;
      tone_q <= 32'h00000000;
      ttp_q <= 32'h00000000;
      stp_q <= 32'h00000000;
      warp_q <= 16'h0000;
      xRem_q <= 16'h0000;
      yRem_q <= 16'h0000;
      wordA_q <= 16'h0000;
      wordB_q <= 16'h0000;
      avm_address <= 32'h00000000;
      avm_read <= 1'b0;
      avm_write <= 1'b0;
      avm_writedata <= 16'h0000;
      drawValid <= 1'b0;
      drawDest <= 32'h00000000;
      drawLen <= 15'h0000;
      drawTone <= 32'h00000000;
      drawToneX <= 16'h0000;
      drawToneWord <= 16'h0000;
      drawUseTone <= 1'b0;
      drawCode <= 8'h00;
    end else begin
      if (wrEn && !busy) begin
        case (avs_address)
          `SLOE_REG_CTRL:  if (avs_byteenable[0]) b2t_q <= avs_writedata[`SLOE_CTRL_B2T];
          `SLOE_REG_LIST:  listPtr_q <= bmerge(listPtr_q, avs_writedata, avs_byteenable);
          `SLOE_REG_BOOL:  {boolHD_q, boolD_q} <= boolMerge[15:0];
          `SLOE_REG_TDIM:  {toneH_q, toneW_q} <=
                             bmerge({toneH_q, toneW_q}, avs_writedata, avs_byteenable);
          `SLOE_REG_BWARP: bandWarp_q <= warpMerge[15:0];
          default: ;
        endcase
      end
      case (state_q)
        S_IDLE: if (goReq) begin
          done_q <= 1'b0;
          fault_q <= 1'b0;
          bad_q <= 1'b0;
          orderPtr_q <= listPtr_q;
          idx_q <= 4'h0;
          state_q <= S_FETCH;
        end
        S_FETCH: if (!avm_read) begin
          avm_address <= orderPtr_q + {27'h0000000, idx_q, 1'b0};
          avm_read <= 1'b1;
        end else if (memDone) begin
          avm_read <= 1'b0;
          buf_q[idx_q] <= avm_readdata;
          if (idx_q == 4'h0) op_q <= avm_readdata[15:8];
          if (idx_q == 4'h0) strip_q <= avm_readdata[7:0];
          if (idx_q + 4'h1 == opLen(idx_q == 4'h0 ? avm_readdata[15:8] : op_q))
            state_q <= S_DEC;
          else
            idx_q <= idx_q + 4'h1;
        end
        S_DEC: begin
          orderPtr_q <= orderPtr_q + {27'h0000000, opLen(op_q), 1'b0};
          idx_q <= 4'h0;
          state_q <= S_SA;
          pos_q <= {buf_q[1], buf_q[2]};
          case (op_q)
            `SLOE_OP_STOP: begin
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
            `SLOE_OP_TDIM: begin
              if (buf_q[3] == 16'h0000 || buf_q[4] == 16'h0000) begin
                bad_q <= 1'b1;
                state_q <= S_IDLE;
              end else begin
                toneW_q <= buf_q[3];
                toneH_q <= buf_q[4];
                state_q <= S_FETCH;
              end
            end
            `SLOE_OP_DFRAME: begin
              warp_q <= buf_q[3];
              stp_q <= {buf_q[4], buf_q[5][15:1], 1'b0};
            end
            `SLOE_OP_TFRAME: begin
              warp_q <= buf_q[3];
              xRem_q <= buf_q[4];
              yRem_q <= buf_q[5];
              tone_q <= {buf_q[6], buf_q[7]};
              ttp_q <= {buf_q[8], buf_q[9][15:1], 1'b0};
              stp_q <= {buf_q[10], buf_q[11][15:1], 1'b0};
            end
            `SLOE_OP_TSTRIP: begin
              warp_q <= bandWarp_q;
              xRem_q <= buf_q[3];
              yRem_q <= buf_q[4];
              tone_q <= {buf_q[5], buf_q[6]};
              ttp_q <= {buf_q[7], buf_q[8][15:1], 1'b0};
              stp_q <= {buf_q[9], buf_q[10][15:1], 1'b0};
            end
            default: begin
              bad_q <= 1'b1;
              state_q <= S_IDLE;
            end
          endcase
        end
        S_SA: if (!avm_read) begin
          avm_address <= stp_q;
          avm_read <= 1'b1;
        end else if (memDone) begin
          avm_read <= 1'b0;
          wordA_q <= avm_readdata;
          if (avm_readdata == 16'h0000) begin
            idx_q <= 4'h0;
            state_q <= S_FETCH;
          end else
            state_q <= S_SB;
        end
        S_SB: if (!avm_read) begin
          avm_address <= b2t_q ? stp_q - 32'h00000002 : stp_q + 32'h00000002;
          avm_read <= 1'b1;
        end else if (memDone) begin
          avm_read <= 1'b0;
          wordB_q <= avm_readdata;
          state_q <= toneOp ? S_TONE : S_DRAW;
        end
        S_TONE: if (!avm_read) begin
          avm_address <= ttp_q;
          avm_read <= 1'b1;
        end else if (memDone) begin
          avm_read <= 1'b0;
          drawToneWord <= avm_readdata;
          state_q <= S_DRAW;
        end
        S_DRAW: if (!drawValid) begin
          if (op_q == `SLOE_OP_TSTRIP && bandFault) begin
            idx_q <= 4'h0;
            state_q <= S_WB;
          end else begin
            drawValid <= 1'b1;
            drawDest <= st;
            drawLen <= run[14:0];
            drawTone <= stTone;
            drawToneX <= xRem_q;
            drawUseTone <= toneOp;
            drawCode <= toneOp ? boolHD_q : boolD_q;
          end
        end else if (drawReady) begin
          drawValid <= 1'b0;
          pos_q <= newPos;
          tone_q <= newTone;
          yRem_q <= newY;
          stp_q <= b2t_q ? stp_q - 32'h00000004 : stp_q + 32'h00000004;
          ttp_q <= b2t_q ? ttp_q - 32'h00000002 : ttp_q + 32'h00000002;
          state_q <= S_SA;
        end
        S_WB: if (!avm_write) begin
          avm_address <= orderPtr_q - {27'h0000000, `SLOE_LEN_TSTRIP, 1'b0}
                         + {27'h0000000, idx_q, 1'b0};
          avm_writedata <= wbWord(idx_q);
          avm_write <= 1'b1;
        end else if (memDone) begin
          avm_write <= 1'b0;
          if (idx_q == `SLOE_LEN_TSTRIP - 4'h1) begin
            fault_q <= 1'b1;
            state_q <= S_IDLE;
          end else
            idx_q <= idx_q + 4'h1;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // sloe_scanline_order_executor
`default_nettype wire

// [verif/sloe_exec_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sloe_defs.vh"
module sloe_exec_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avm_address,
  input wire logic        avm_read,
  input wire logic        avm_write,
  input wire logic [15:0] avm_writedata,
  input wire logic        avm_waitrequest,
  input wire logic        drawValid,
  input wire logic        drawReady,
  input wire logic [31:0] drawDest,
  input wire logic        drawUseTone,
  input wire logic [7:0]  drawCode,
  input wire logic        bandFault
);
  // ----------
  // Checks
  // ----------
  logic [15:0] boolQ;
  always @(posedge ref_clk)
    if (rst) boolQ <= 16'h0000;
    else if (avs_write && !avs_waitrequest && avs_address == `SLOE_REG_BOOL)
      boolQ <= avs_writedata[15:0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence busTaken; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence busAnswer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  bus_answer_a: assert property (busTaken |=> busAnswer)
    else $error("register access not answered next cycle");
  answer_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> avs_waitrequest && !avm_read && !avm_write && !drawValid)
    else $error("outputs active after reset");
  draw_hold_a: assert property (
    drawValid && !drawReady |=> drawValid && $stable({drawDest, drawCode, drawUseTone}))
    else $error("draw request changed before accept");
  code_pick_a: assert property (
    drawValid |-> drawCode == (drawUseTone ? boolQ[15:8] : boolQ[7:0]))
    else $error("wrong logic code on draw");
  mem_excl_a: assert property (!(avm_read && avm_write))
    else $error("memory read and write together");
  mem_hold_a: assert property ((avm_read || avm_write) && avm_waitrequest
    |=> $stable({avm_read, avm_write, avm_address, avm_writedata}))
    else $error("memory request changed while waiting");
  fault_only_a: assert property (avm_write |-> bandFault)
    else $error("order rewritten without band fault");
  mem_align_a: assert property ((avm_read || avm_write) |-> !avm_address[0])
    else $error("odd memory address");
endmodule // sloe_exec_assertions
bind sloe_scanline_order_executor sloe_exec_assertions u_chk (.ref_clk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .avm_address, .avm_read, .avm_write,
  .avm_writedata, .avm_waitrequest, .drawValid, .drawReady, .drawDest, .drawUseTone, .drawCode,
  .bandFault);
`default_nettype wire

// [verif/sloe_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sloe_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        slowMode,
  input  wire logic [31:0] avm_address,
  input  wire logic        avm_read,
  input  wire logic        avm_write,
  input  wire logic [15:0] avm_writedata,
  output logic      [15:0] avm_readdata,
  output logic             avm_waitrequest
);
  // ----------
  // Shared memory
  // ----------
  logic [15:0] mem [0:4095];
  logic [15:0] lastQ = 16'h0000;
  logic [1:0]  waitQ = 2'h0;
  logic        grant;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // Slow mode stalls every access two cycles
  assign grant = (avm_read || avm_write) && (!slowMode || waitQ == 2'h2);
  assign avm_waitrequest = ~grant;
  // Word-aligned byte address picks a word
  assign avm_readdata = (grant && avm_read) ? mem[avm_address[12:1]] : ~lastQ;
  always @(posedge ref_clk) begin
    waitQ <= (grant || !(avm_read || avm_write)) ? 2'h0 : waitQ + 2'h1;
    if (grant && avm_write)
      mem[avm_address[12:1]] <= avm_writedata;
    if (grant && avm_read)
      lastQ <= mem[avm_address[12:1]];
  end
endmodule // sloe_mem_model
`default_nettype wire

// [verif/scanline_order_executor_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sloe_defs.vh"
module scanline_order_executor_test;
  logic         refClk = 1'b0;
  logic         rst = 1'b1;
  logic [5:0]   avsAddress = 6'h00;
  logic         avsRead = 1'b0;
  logic         avsWrite = 1'b0;
  logic         drawReady = 1'b1;
  logic         bandFault = 1'b0;
  logic         slowMode = 1'b0;
  logic [31:0]  avsWritedata = 32'h0, avsReaddata, avmAddress, drawDest, drawTone;
  logic         avsWaitrequest, avmRead, avmWrite, avmWaitrequest, drawValid, drawUseTone;
  logic [15:0]  avmWritedata, avmReaddata, drawToneX, drawToneWord;
  logic [14:0]  drawLen;
  logic [7:0]   drawCode;
  logic [119:0] gAll;
  int           badCount = 0, checksDone = 0, cycles = 0, draws = 0;
  sloe_scanline_order_executor u_dut (.ref_clk(refClk), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .avm_address(avmAddress), .avm_read(avmRead), .avm_write(avmWrite),
    .avm_writedata(avmWritedata), .avm_readdata(avmReaddata), .avm_waitrequest(avmWaitrequest),
    .drawValid(drawValid), .drawReady(drawReady), .drawDest(drawDest), .drawLen(drawLen),
    .drawTone(drawTone), .drawToneX(drawToneX), .drawToneWord(drawToneWord),
    .drawUseTone(drawUseTone), .drawCode(drawCode), .bandFault(bandFault));
  sloe_mem_model u_mem (.ref_clk(refClk), .slowMode(slowMode), .avm_address(avmAddress),
    .avm_read(avmRead), .avm_write(avmWrite), .avm_writedata(avmWritedata),
    .avm_readdata(avmReaddata), .avm_waitrequest(avmWaitrequest));
  // ----------
  // Clock, draw sink, timeout
  // ----------
  always #2 refClk = ~refClk;
  always @(posedge refClk) begin
    cycles++;
    drawReady <= ~drawReady;
    if (drawValid === 1'b1 && drawReady) begin
      draws++;
      gAll = {drawDest, drawTone, drawToneX, drawToneWord, drawLen, drawUseTone, drawCode};
    end
    if (cycles == 20000) begin
      badCount++;
      giveVerdict();
    end
  end
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    @(posedge refClk);
    while (avsWaitrequest !== 1'b0) @(posedge refClk);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge refClk);
  endtask
  task automatic put(input int a, input logic [15:0] w [0:11]);
    for (int i = 0; i < 12; i++) u_mem.mem[a / 2 + i] = w[i];
  endtask
  task automatic run(input logic [31:0] list, input logic b2t, output logic [31:0] st);
    logic [31:0] q;
    draws = 0;
    bus(1'b1, `SLOE_REG_LIST, list, q);
    bus(1'b1, `SLOE_REG_CTRL, {30'h0, b2t, 1'b1}, q);
    st = 32'h1;
    while (st[0] !== 1'b0) bus(1'b0, `SLOE_REG_STATUS, 32'h0, st);
    st = st & 32'h0000000F;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic test_regs();
    logic [31:0] q;
    bus(1'b0, `SLOE_REG_TDIM, 32'h0, q);
    check(q, 32'h00010001, "tone dims reset");
    bus(1'b0, 6'h18, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    bus(1'b1, `SLOE_REG_BOOL, 32'h0000C35A, q);
    bus(1'b1, 6'h18, 32'hFFFFFFFF, q);
    bus(1'b0, `SLOE_REG_BOOL, 32'h0, q);
    check(q, 32'h0000C35A, "logic codes");
    put(32'h280, '{0:16'h0B00, 4:16'h0005, default:16'h0000});
    run(32'h280, 1'b0, q);
    check({31'h0, q[3]}, 32'h1, "zero tone width");
    $display("register test done");
  endtask
  task automatic test_dframe();
    logic [31:0] st;
    put(32'h100, '{0:16'h14A5, 1:16'h0001, 2:16'h2340, 3:16'h0100, 5:16'h0400,
                   default:16'h0000});
    put(32'h400, '{0:16'h0010, 1:16'h0008, default:16'h0000});
    run(32'h100, 1'b0, st);
    check(st, 32'h2, "stop status");
    check(draws, 1, "draw count");
    check(gAll[119:88], 32'h00012350, "draw dest");
    check({17'h0, gAll[23:9]}, 32'h8, "run length");
    check({23'h0, gAll[8:0]}, 32'h5A, "one-operand code");
    $display("frame test done");
  endtask
  task automatic test_tframe();
    logic [31:0] st;
    slowMode <= 1'b1;
    put(32'h200, '{16'h0B00, 16'h0000, 16'h0080, 16'h0010, 16'h0008, 16'h1500, 16'h0003,
                   16'h0000, 16'h0040, 16'h0005, 16'h0003, 16'h0000});
    put(32'h218, '{0:16'h0900, 2:16'h0500, 4:16'h0440, default:16'h0000});
    put(32'h440, '{0:16'h0002, 1:16'h0005, default:16'h0000});
    put(32'h500, '{0:16'hBEEF, default:16'h0000});
    run(32'h200, 1'b0, st);
    slowMode <= 1'b0;
    check(st, 32'h2, "stop status");
    check(gAll[119:88], 32'h00030002, "draw dest");
    check(gAll[87:56], 32'h00000902, "tone address");
    check({gAll[55:40], gAll[39:24]}, 32'h0005BEEF, "tone x and word");
    check({23'h0, gAll[8:0]}, 32'h1C3, "two-operand code");
    $display("tone frame test done");
  endtask
  task automatic test_strip(input logic b2t, input logic flt);
    logic [31:0] st;
    logic [15:0] sl;
    sl = b2t ? 16'h0602 : 16'h0600;
    put(32'h300, '{16'h3507, 16'h0005, 16'h0000, 16'h0004, 16'h0002, 16'h0000, 16'h0A00,
                   16'h0000, 16'h0700, 16'h0000, sl, 16'h0000});
    put(32'h5FC, '{2:16'h0002, 3:16'h0004, default:16'h0000});
    put(32'h6FE, '{1:16'h1234, default:16'h0000});
    slowMode <= flt;
    bandFault <= flt;
    run(32'h300, b2t, st);
    bandFault <= 1'b0;
    slowMode <= 1'b0;
    if (flt) begin
      check(st, 32'h4, "fault status");
      check({16'h0, u_mem.mem[32'h180]}, b2t ? 32'h3506 : 32'h3508, "strip index");
      check({16'h0, u_mem.mem[32'h184]}, 32'h0002, "lines left");
      check({u_mem.mem[32'h181], u_mem.mem[32'h182]}, 32'h00050000, "dest back");
      check({u_mem.mem[32'h185], u_mem.mem[32'h186]}, 32'h00000A00, "tone back");
      check({u_mem.mem[32'h187], u_mem.mem[32'h188]}, 32'h0700, "tone ptr");
      check({u_mem.mem[32'h189], u_mem.mem[32'h18A]}, {16'h0, sl}, "scan ptr");
      check({16'h0, u_mem.mem[32'h301]}, 32'h0004, "table kept");
      check(draws, 0, "no draw on fault");
    end else begin
      check(st, 32'h2, "stop status");
      check(gAll[119:88], b2t ? 32'h0004FFFC : 32'h00050002, "draw dest");
      check({16'h0, gAll[39:24]}, 32'h1234, "tone word");
      check({23'h0, gAll[8:0]}, 32'h1C3, "two-operand code");
    end
    $display("strip test b2t %0b fault %0b done", b2t, flt);
  endtask
  initial begin
    repeat (16) @(posedge refClk);
    rst <= 1'b0;
    @(posedge refClk);
    test_regs();
    test_dframe();
    test_tframe();
    test_strip(1'b0, 1'b0);
    test_strip(1'b1, 1'b0);
    test_strip(1'b0, 1'b1);
    test_strip(1'b1, 1'b1);
    giveVerdict();
  end
endmodule // scanline_order_executor_test
`default_nettype wire
